// [hdl/mct_defs.svh]
// Register offsets, field positions and reset values of the timer
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH
`define MCT_OFF_CTRL 8'h00
`define MCT_OFF_PSC 8'h04
`define MCT_OFF_ARR 8'h08
`define MCT_OFF_CNT 8'h0c
`define MCT_OFF_STAT 8'h10
`define MCT_OFF_MASK 8'h14
`define MCT_OFF_DTIME 8'h18
`define MCT_OFF_CHMODE 8'h1c
`define MCT_OFF_CCR_BASE 4'h2
`define MCT_CTRL_EN 0
`define MCT_CTRL_MODE 1
`define MCT_CTRL_OPM 3
`define MCT_CTRL_FRZ 4
`define MCT_CTRL_NARROW 5
`define MCT_CTRL_SINGLE 6
`define MCT_CTRL_ENC 7
`define MCT_CTRL_HALL 8
`define MCT_CTRL_SLAVE 9
`define MCT_CTRL_DMA 10
`define MCT_CTRL_COMPL 11
`define MCT_CTRL_W 12
`define MCT_STAT_UPD 0
`define MCT_STAT_CH0 1
`define MCT_STAT_TRG 5
`define MCT_STAT_HALL 6
`define MCT_STAT_W 7
`define MCT_ARR_RST 32'hffff_ffff
`define MCT_NUM_CH 4
`endif

// [hdl/mct_pkg.sv]
// Types shared by the timer modules
`default_nettype none
package mct_pkg;
    typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER} mct_cnt_mode_e;
    typedef enum logic [1:0] {CH_OFF, CH_TOGGLE, CH_PWM, CH_CAPTURE} mct_ch_mode_e;
    typedef enum logic {DIR_UP, DIR_DOWN} mct_dir_e;
endpackage : mct_pkg
`default_nettype wire

// [hdl/mct_ch_if.sv]
// Signals between the counter core and one capture/compare channel
`default_nettype none
interface mct_ch_if;
    import mct_pkg::*;
    logic [31:0] cnt;
    logic [31:0] ccr;
    logic tick;
    mct_ch_mode_e mode;
    logic complEn;
    logic [7:0] deadTime;
    logic capIn;
    logic outP;
    logic outN;
    logic match;
    logic capEvt;
    modport core (output cnt, ccr, tick, mode, complEn, deadTime, capIn,
                  input outP, outN, match, capEvt);
    modport chan (input cnt, ccr, tick, mode, complEn, deadTime, capIn,
                  output outP, outN, match, capEvt);
endinterface : mct_ch_if
`default_nettype wire

// [hdl/mct_prescaler.sv]
// Counter clock prescaler, divide by div plus one
`default_nettype none
module mct_prescaler
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic restart,
    input wire logic [15:0] div,
    output logic tick
);
    logic [15:0] pre_r;

    // Tick after div+1 running cycles, so factors 1 to 65536
    always_ff @(posedge clk)
    begin
        if (srst || restart)
        begin
            pre_r <= 16'h0000;
            tick <= 1'b0;
        end
        else if (run)
        begin
            tick <= (pre_r >= div);
            pre_r <= (pre_r >= div) ? 16'h0000 : pre_r + 16'h0001;
        end
        else
        begin
            tick <= 1'b0;
        end
    end

    a_psc_spacing: assert property (@(posedge clk) disable iff (srst)
        (tick && div != 16'h0000 && $stable(div) && !restart) |=> !tick)
        else $error("prescaler ticked twice in a row");
endmodule : mct_prescaler
`default_nettype wire

// [hdl/mct_channel.sv]
// One capture/compare channel with complementary dead-time output
`default_nettype none
module mct_channel
(
    input wire logic clk,
    input wire logic srst,
    mct_ch_if.chan ch
);
    import mct_pkg::*;
    logic capPrev_r;
    logic raw_r;
    logic rawNxt;
    logic [7:0] dt_r;

    // Raw waveform: PWM compare or toggle on match
    always_comb
    begin
        rawNxt = 1'b0;
        case (ch.mode)
            CH_PWM: rawNxt = (ch.cnt < ch.ccr);
            CH_TOGGLE: rawNxt = raw_r ^ (ch.tick && ch.cnt == ch.ccr);
            default: rawNxt = 1'b0;
        endcase
    end

    // Capture edge and compare match events
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            capPrev_r <= 1'b0;
            ch.capEvt <= 1'b0;
            ch.match <= 1'b0;
        end
        else
        begin
            capPrev_r <= ch.capIn;
            ch.capEvt <= (ch.mode == CH_CAPTURE) && ch.capIn && !capPrev_r;
            ch.match <= ch.tick && (ch.cnt == ch.ccr) &&
                        (ch.mode == CH_TOGGLE || ch.mode == CH_PWM);
        end
    end

    // Both legs idle for deadTime plus one cycles after each raw change
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            raw_r <= 1'b0;
            dt_r <= 8'h00;
            ch.outP <= 1'b0;
            ch.outN <= 1'b0;
        end
        else
        begin
            raw_r <= rawNxt;
            dt_r <= (rawNxt != raw_r) ? ch.deadTime : (dt_r != 8'h00 ? dt_r - 8'h01 : 8'h00);
            ch.outP <= raw_r && dt_r == 8'h00 && rawNxt == raw_r;
            ch.outN <= ch.complEn && ch.mode != CH_OFF && !raw_r &&
                       dt_r == 8'h00 && rawNxt == raw_r;
        end
    end

    a_legs_exclusive: assert property (@(posedge clk) disable iff (srst)
        !(ch.outP && ch.outN))
        else $error("both legs of a pair driven");
    a_pwm_full_off: assert property (@(posedge clk) disable iff (srst)
        (ch.mode == CH_PWM && ch.ccr == 32'h0000_0000) [*3] |-> !ch.outP)
        else $error("zero duty still drives output");
endmodule : mct_channel
`default_nettype wire

// [hdl/mct_timer.sv]
// Multi-channel timer: counter, register file, channels and events
`default_nettype none
`include "mct_defs.svh"
// Function
// - Wide mode: 32-bit up/down/centre reload counter
// - Narrow mode: 16-bit counter, all directions, prescaled
// - Single-channel mode: 16-bit up counter only
// - Prescaler divides by 1 to 65536
// - Channels capture, compare, PWM or one-pulse
// - Complementary outputs with programmable dead time
// - Three phases over six main/complement outputs
// - PWM duty spans zero to full on
// - Four independent channels in general modes
// - Trigger in/out links timers together
// - Own DMA requests per timer
// - Quadrature encoder and hall sensor inputs
// - Single-channel mode keeps one channel
// - Complementary single mode has DMA, basic none
// - Counter freezes while debugger halts core
module mct_timer
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic dbgHalt,
    input wire logic trigIn,
    input wire logic encA,
    input wire logic encB,
    input wire logic [2:0] hallIn,
    input wire logic [3:0] capIn,
    output logic [3:0] pwmOut,
    output logic [3:0] pwmOutN,
    output logic trigOut,
    output logic dmaReq,
    output logic irq
);
    import mct_pkg::*;

    logic [`MCT_CTRL_W-1:0] ctrl_r;
    logic [15:0] psc_r;
    logic [31:0] arr_r;
    logic [31:0] cnt_r;
    logic [31:0] cntNxt;
    logic [`MCT_STAT_W-1:0] status_r;
    logic [`MCT_STAT_W-1:0] mask_r;
    logic [`MCT_STAT_W-1:0] events;
    logic [7:0] dtime_r;
    logic [7:0] chmode_r;
    logic [31:0] ccr_r [`MCT_NUM_CH];
    mct_dir_e dir_r;
    logic encA_r;
    logic encB_r;
    logic [2:0] hall_r;
    logic narrow;
    logic single;
    logic encMode;
    logic run;
    logic pscTick;
    logic encEdge;
    logic encUp;
    logic cntTick;
    logic goUp;
    logic wrapUp;
    logic wrapDown;
    logic updEvt;
    logic hallEdge;
    logic ctrReset;
    logic wrCnt;
    logic [31:0] arrM;
    logic [3:0] chEvt;
    logic dmaAllowed;
    mct_cnt_mode_e effMode;

    // Keep the low half only when a 16-bit counter is selected
    function automatic logic [31:0] mct_mask(input logic [31:0] v, input logic nar);
        mct_mask = nar ? {16'h0000, v[15:0]} : v;
    endfunction : mct_mask

    // Address of a capture/compare register, any of the four
    function automatic logic is_ccr(input logic [7:0] a);
        is_ccr = (a[7:4] == `MCT_OFF_CCR_BASE) && (a[1:0] == 2'b00);
    endfunction : is_ccr

    // Variant and mode decode
    assign narrow = ctrl_r[`MCT_CTRL_NARROW] || ctrl_r[`MCT_CTRL_SINGLE];
    assign single = ctrl_r[`MCT_CTRL_SINGLE];
    assign encMode = ctrl_r[`MCT_CTRL_ENC] && !single;
    assign arrM = mct_mask(arr_r, narrow);
    assign wrCnt = regWrite && regAddr == `MCT_OFF_CNT;

    always_comb
    begin
        if (single || ctrl_r[`MCT_CTRL_MODE+1 -: 2] == 2'b00)
            effMode = CNT_UP;
        else if (ctrl_r[`MCT_CTRL_MODE+1 -: 2] == 2'b01)
            effMode = CNT_DOWN;
        else
            effMode = CNT_CENTER;
    end

    // Freeze while the core is halted, if software asks for it
    assign run = ctrl_r[`MCT_CTRL_EN] && !(ctrl_r[`MCT_CTRL_FRZ] && dbgHalt);

    mct_prescaler u_psc
    (
        .clk(clk),
        .srst(srst),
        .run(run && !encMode),
        .restart(ctrReset),
        .div(psc_r),
        .tick(pscTick)
    );

    // Quadrature and hall input history; inputs are already synchronous
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            encA_r <= 1'b0;
            encB_r <= 1'b0;
            hall_r <= 3'h0;
        end
        else
        begin
            encA_r <= encA;
            encB_r <= encB;
            hall_r <= hallIn;
        end
    end

    // Count on every encoder edge, direction from phase order
    assign encEdge = (encA != encA_r) || (encB != encB_r);
    assign encUp = encA_r ^ encB;
    // A hall transition that flips an odd number of sensors (parity change): one to three sensors, unused tied low
    assign hallEdge = ctrl_r[`MCT_CTRL_HALL] && (^hallIn != ^hall_r);
    assign ctrReset = hallEdge || (ctrl_r[`MCT_CTRL_SLAVE] && trigIn);

    // Gate the registered tick too, or one stale count slips past a freeze or stop
    assign cntTick = encMode ? (run && encEdge) : (run && pscTick);
    assign goUp = encMode ? encUp :
                  (effMode == CNT_UP || (effMode == CNT_CENTER && dir_r == DIR_UP));
    assign wrapUp = cnt_r >= arrM;
    assign wrapDown = cnt_r == 32'h0000_0000;
    assign updEvt = cntTick && !ctrReset && !wrCnt &&
                    (goUp ? wrapUp : wrapDown);

    // Next count: wrap to zero, reload from top, or turn round in centre mode
    always_comb
    begin
        cntNxt = cnt_r;
        if (goUp)
        begin
            if (!wrapUp)
                cntNxt = cnt_r + 32'h0000_0001;
            else if (effMode == CNT_CENTER && !encMode && arrM != 32'h0000_0000)
                cntNxt = arrM - 32'h0000_0001;
            else
                cntNxt = 32'h0000_0000;
        end
        else
        begin
            if (!wrapDown)
                cntNxt = cnt_r - 32'h0000_0001;
            else if (effMode == CNT_CENTER && !encMode)
                cntNxt = (arrM != 32'h0000_0000) ? 32'h0000_0001 : 32'h0000_0000;
            else
                cntNxt = arrM;
        end
    end

    // Counter register; software write beats trigger reset beats counting
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_r <= 32'h0000_0000;
        else if (wrCnt)
            cnt_r <= mct_mask(regWdata, narrow);
        else if (ctrReset)
            cnt_r <= 32'h0000_0000;
        else if (cntTick)
            cnt_r <= mct_mask(cntNxt, narrow);
        else
            cnt_r <= mct_mask(cnt_r, narrow);
    end

    // Centre-aligned direction state
    always_ff @(posedge clk)
    begin
        if (srst)
            dir_r <= DIR_UP;
        else if (effMode != CNT_CENTER || ctrReset)
            dir_r <= DIR_UP;
        else if (updEvt)
        begin
            case (dir_r)
                DIR_UP: dir_r <= DIR_DOWN;
                DIR_DOWN: dir_r <= DIR_UP;
                default: dir_r <= DIR_UP;
            endcase
        end
    end

    // Control register; one-pulse mode stops the counter at its update
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_r <= '0;
        else if (regWrite && regAddr == `MCT_OFF_CTRL)
            ctrl_r <= regWdata[`MCT_CTRL_W-1:0];
        else if (updEvt && ctrl_r[`MCT_CTRL_OPM])
            ctrl_r[`MCT_CTRL_EN] <= 1'b0;
    end

    // Plain configuration registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            psc_r <= 16'h0000;
            arr_r <= `MCT_ARR_RST;
            mask_r <= '0;
            dtime_r <= 8'h00;
            chmode_r <= 8'h00;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `MCT_OFF_PSC: psc_r <= regWdata[15:0];
                `MCT_OFF_ARR: arr_r <= regWdata;
                `MCT_OFF_MASK: mask_r <= regWdata[`MCT_STAT_W-1:0];
                `MCT_OFF_DTIME: dtime_r <= regWdata[7:0];
                `MCT_OFF_CHMODE: chmode_r <= regWdata[7:0];
                default: ;
            endcase
        end
    end

    // Four channels; in single mode only channel 0 stays live
    genvar gi;
    generate
        for (gi = 0; gi < `MCT_NUM_CH; gi++)
        begin : g_ch
            mct_ch_if chIf ();
            assign chIf.cnt = cnt_r;
            assign chIf.ccr = mct_mask(ccr_r[gi], narrow);
            assign chIf.tick = cntTick;
            assign chIf.mode = (single && gi != 0) ? CH_OFF :
                               mct_ch_mode_e'(chmode_r[2*gi+1 -: 2]);
            // Basic single mode has no complementary leg
            assign chIf.complEn = ctrl_r[`MCT_CTRL_COMPL];
            assign chIf.deadTime = dtime_r;
            assign chIf.capIn = capIn[gi];
            assign pwmOut[gi] = chIf.outP;
            assign pwmOutN[gi] = chIf.outN;
            assign chEvt[gi] = chIf.match || chIf.capEvt || (gi == 0 && hallEdge);
            mct_channel u_ch
            (
                .clk(clk),
                .srst(srst),
                .ch(chIf.chan)
            );

            // Capture loads the count, winning over a software write
            always_ff @(posedge clk)
            begin
                if (srst)
                    ccr_r[gi] <= 32'h0000_0000;
                else if (chIf.capEvt || (gi == 0 && hallEdge))
                    ccr_r[gi] <= cnt_r;
                else if (regWrite && is_ccr(regAddr) && regAddr[3:2] == gi)
                    ccr_r[gi] <= regWdata;
            end
        end
    endgenerate

    // Sticky status; a read clears, a new event in that cycle still sets
    assign events = {hallEdge, ctrl_r[`MCT_CTRL_SLAVE] && trigIn, chEvt, updEvt};
    always_ff @(posedge clk)
    begin
        if (srst)
            status_r <= '0;
        else
            status_r <= ((regRead && regAddr == `MCT_OFF_STAT) ? '0 : status_r)
                        | events;
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(status_r & mask_r);
    end

    // Trigger out and DMA request pulses; the basic single mode has no DMA
    assign dmaAllowed = !(single && !ctrl_r[`MCT_CTRL_COMPL]);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            trigOut <= 1'b0;
            dmaReq <= 1'b0;
        end
        else
        begin
            trigOut <= updEvt;
            dmaReq <= ctrl_r[`MCT_CTRL_DMA] && dmaAllowed && (updEvt || |chEvt);
        end
    end

    // Read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (srst)
            regRdata <= 32'h0000_0000;
        else if (regRead)
        begin
            case (regAddr)
                `MCT_OFF_CTRL: regRdata <= {20'h00000, ctrl_r};
                `MCT_OFF_PSC: regRdata <= {16'h0000, psc_r};
                `MCT_OFF_ARR: regRdata <= arr_r;
                `MCT_OFF_CNT: regRdata <= cnt_r;
                `MCT_OFF_STAT: regRdata <= {24'h000000, dir_r == DIR_DOWN, status_r};
                `MCT_OFF_MASK: regRdata <= {25'h0000000, mask_r};
                `MCT_OFF_DTIME: regRdata <= {24'h000000, dtime_r};
                `MCT_OFF_CHMODE: regRdata <= {24'h000000, chmode_r};
                default: regRdata <= is_ccr(regAddr) ? ccr_r[regAddr[3:2]] : 32'h0000_0000;
            endcase
        end
        else
            regRdata <= 32'h0000_0000;
    end

    a_up_wrap: assert property (@(posedge clk) disable iff (srst)
        (cntTick && !ctrReset && !wrCnt && effMode == CNT_UP && !encMode && wrapUp)
        |=> (cnt_r == 32'h0000_0000 && status_r[`MCT_STAT_UPD] && trigOut))
        else $error("up count did not wrap with update");
    a_down_reload: assert property (@(posedge clk) disable iff (srst)
        (cntTick && !ctrReset && !wrCnt && effMode == CNT_DOWN && !encMode &&
         wrapDown && $stable(arr_r)) |=> (cnt_r == arrM))
        else $error("down count did not reload");
    a_narrow_width: assert property (@(posedge clk) disable iff (srst)
        (narrow && $stable(narrow)) |-> ##1 (!narrow || cnt_r[31:16] == 16'h0000))
        else $error("narrow counter exceeds 16 bits");
    a_freeze_halt: assert property (@(posedge clk) disable iff (srst)
        (ctrl_r[`MCT_CTRL_FRZ] && dbgHalt && !wrCnt && !ctrReset) |=> $stable(cnt_r))
        else $error("counter moved during debug halt");
    a_single_off: assert property (@(posedge clk) disable iff (srst)
        single [*4] |-> (pwmOut[3:1] == 3'b000))
        else $error("idle channel driven in single mode");
    a_basic_nodma: assert property (@(posedge clk) disable iff (srst)
        (single && !ctrl_r[`MCT_CTRL_COMPL]) |=> !dmaReq)
        else $error("basic single mode raised DMA");
    a_read_cnt: assert property (@(posedge clk) disable iff (srst)
        (regRead && regAddr == `MCT_OFF_CNT) |=> (regRdata == $past(cnt_r)))
        else $error("count read back wrong");
    a_irq_follow: assert property (@(posedge clk) disable iff (srst)
        (status_r[`MCT_STAT_UPD] && mask_r[`MCT_STAT_UPD]) |=> irq)
        else $error("unmasked update did not raise irq");
endmodule : mct_timer
`default_nettype wire

// [dv/mct_sensor_model.sv]
// Quadrature encoder and hall sensor model facing the timer inputs
`default_nettype none
module mct_sensor_model
(
    input wire logic clk,
    output logic encA,
    output logic encB,
    output logic [2:0] hallIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    // Gray order, so only one line moves per step
    assign encA = ph[1];
    assign encB = ph[1] ^ ph[0];
    initial
    begin
        hallIn = 3'h0;
    end
    // One edge, then a gap so the timer samples every state
    task step(input bit up);
        @(posedge clk);
        ph <= up ? ph + 2'h1 : ph - 2'h1;
        repeat (4) @(posedge clk);
    endtask : step
    // Johnson sequence: one sensor changes, so their parity flips
    task hallStep();
        @(posedge clk);
        hallIn <= {hallIn[1:0], ~hallIn[2]};
    endtask : hallStep
endmodule : mct_sensor_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the multi-channel timer
`default_nettype none
`include "mct_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic dbgHalt = 1'b0;
    logic trigIn = 1'b0;
    logic [3:0] capIn = 4'h0;
    logic [31:0] regRdata;
    logic encA;
    logic encB;
    logic [2:0] hallIn;
    logic [3:0] pwmOut;
    logic [3:0] pwmOutN;
    logic trigOut;
    logic dmaReq;
    logic irq;
    logic [31:0] rd;
    logic [31:0] x;
    int err_count = 0;
    int tests_run = 0;
    int n, p, a, hi, lo, dm, bh;
    int duty[3] = '{0, 4, 10};

    mct_timer uut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .dbgHalt(dbgHalt),
        .trigIn(trigIn), .encA(encA), .encB(encB), .hallIn(hallIn), .capIn(capIn),
        .pwmOut(pwmOut), .pwmOutN(pwmOutN), .trigOut(trigOut), .dmaReq(dmaReq), .irq(irq));
    mct_sensor_model sens (.clk(clk), .encA(encA), .encB(encB), .hallIn(hallIn));

    // 25 MHz clock
    initial
    begin
        forever #20 clk = ~clk;
    end

    function automatic int expPer(int ar, int ps);
        return (ar + 1) * (ps + 1);
    endfunction : expPer

    // High cycles of edge PWM over whole periods; the dead band eats one per rise
    function automatic int expHigh(int c, int ar, int cyc);
        return (c == 0 ? 0 : (c > ar ? ar + 1 : c - 1)) * cyc / (ar + 1);
    endfunction : expHigh

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        regAddr <= ad;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rdr(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rdr

    task setup(input logic [31:0] psc, input logic [31:0] arr, input logic [31:0] ctl);
        wr(`MCT_OFF_CTRL, 32'h0);
        wr(`MCT_OFF_PSC, psc);
        wr(`MCT_OFF_ARR, arr);
        wr(`MCT_OFF_CNT, 32'h0);
        wr(`MCT_OFF_CTRL, ctl);
    endtask : setup

    // Cycles up to the next reload pulse, bounded so a dead counter ends the run
    task waitTrig(output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            c++;
        end while (trigOut !== 1'b1 && c < 5000);
        if (c >= 5000)
        begin
            chk(32'h1, 32'h0);
            print_verdict();
        end
    endtask : waitTrig

    task watch(input int cyc, output int h, output int l, output int d, output int b);
        h = 0;
        l = 0;
        d = 0;
        b = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            h += int'(pwmOut[0] === 1'b1);
            l += int'(pwmOut[0] === 1'b0 && pwmOutN[0] === 1'b0);
            b += int'(pwmOut[0] === 1'b1 && pwmOutN[0] === 1'b1);
            d += int'(dmaReq === 1'b1);
        end
    endtask : watch

    // Main sequence
    initial
    begin
        x = $urandom(32'h8084);
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdr(`MCT_OFF_ARR, rd);
        chk(rd, `MCT_ARR_RST);
        wr(8'h3c, 32'hffffffff);
        rdr(8'h3c, rd);
        chk(rd, 32'h0);
        // Random prescale, reload and direction: reload period
        repeat (5)
        begin
            p = $urandom % 4;
            a = 1 + $urandom % 6;
            setup(p, a, 32'h1 | (($urandom % 2) << 1));
            waitTrig(n);
            waitTrig(n);
            chk(n, expPer(a, p));
            rdr(`MCT_OFF_STAT, rd);
            chk(rd[0], 1'b1);
        end
        // Centre mode turns at both ends, an update at each
        setup(1, 4, 32'h5);
        waitTrig(n);
        waitTrig(n);
        chk(n, 4 * 2);
        // Debug freeze holds a count, capture grabs it
        dbgHalt <= 1'b1;
        x = $urandom;
        setup(0, 32'hffffffff, 32'h11);
        wr(`MCT_OFF_CNT, x);
        wr(`MCT_OFF_CHMODE, 32'hc);
        capIn <= 4'h2;
        repeat (3) @(posedge clk);
        rdr(8'h24, rd);
        chk(rd, x);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, x);
        rdr(`MCT_OFF_STAT, rd);
        chk(rd[2], 1'b1);
        capIn <= 4'h0;
        dbgHalt <= 1'b0;
        repeat (8) @(posedge clk);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd !== x, 1'b1);
        // Narrow and single modes keep 16 count bits
        wr(`MCT_OFF_CTRL, 32'h20);
        wr(`MCT_OFF_CNT, 32'habcd1234);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, 32'h1234);
        wr(`MCT_OFF_CTRL, 32'h40);
        wr(`MCT_OFF_CNT, 32'h5678abcd);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, 32'habcd);
        // PWM duty from off to fully on
        wr(`MCT_OFF_CHMODE, 32'h2);
        setup(0, 9, 32'h1);
        foreach (duty[i])
        begin
            wr(8'h20, duty[i]);
            repeat (5) @(posedge clk);
            watch(30, hi, lo, dm, bh);
            chk(hi, expHigh(duty[i], 9, 30));
        end
        // Complementary pair: both low for dead time plus one per edge
        wr(`MCT_OFF_DTIME, 32'h3);
        wr(8'h20, 32'h5);
        wr(`MCT_OFF_CTRL, 32'h801);
        repeat (10) @(posedge clk);
        watch(40, hi, lo, dm, bh);
        chk(lo, 4 * 2 * (3 + 1));
        chk(bh, 0);
        // Three phases on six legs, channel 3 idle; single mode keeps channel 0 only
        wr(`MCT_OFF_CHMODE, 32'h2a);
        wr(8'h24, 32'h0);
        wr(8'h28, 32'ha);
        repeat (10) @(posedge clk);
        chk({pwmOut[3:1], pwmOutN[3:1]}, 6'b010_001);
        wr(`MCT_OFF_CTRL, 32'h841);
        repeat (10) @(posedge clk);
        chk({pwmOut[3:1], pwmOutN[3:1]}, 6'h00);
        wr(`MCT_OFF_CHMODE, 32'h0);
        // Interrupt: raised, cleared by read, then masked
        wr(`MCT_OFF_MASK, 32'h1);
        setup(0, 2, 32'h1);
        waitTrig(n);
        wr(`MCT_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rdr(`MCT_OFF_STAT, rd);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rdr(`MCT_OFF_STAT, rd);
        chk(rd[0], 1'b0);
        wr(`MCT_OFF_MASK, 32'h0);
        wr(`MCT_OFF_CTRL, 32'h1);
        waitTrig(n);
        wr(`MCT_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        // Trigger from another timer holds the counter at zero
        setup(0, 32'hffff, 32'h201);
        trigIn <= 1'b1;
        repeat (5) @(posedge clk);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, 32'h0);
        trigIn <= 1'b0;
        rdr(`MCT_OFF_STAT, rd);
        chk(rd[5], 1'b1);
        // DMA pulses per update; basic single mode makes none
        setup(0, 3, 32'h401);
        repeat (4) @(posedge clk);
        watch(20, hi, lo, dm, bh);
        chk(dm, 20 / 4);
        wr(`MCT_OFF_CTRL, 32'h441);
        repeat (4) @(posedge clk);
        watch(20, hi, lo, dm, bh);
        chk(dm, 0);
        // One-pulse mode stops at its first update and stays at zero
        setup(0, 3, 32'h9);
        repeat (12) @(posedge clk);
        rdr(`MCT_OFF_CTRL, rd);
        chk(rd, 32'h8);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, 32'h0);
        // Encoder: six edges forward, two back
        setup(0, 32'hffff, 32'h81);
        repeat (6) sens.step(1'b1);
        repeat (2) sens.step(1'b0);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd, 32'h4);
        // Hall change flags an edge and restarts the count
        setup(0, 32'hffff, 32'h101);
        repeat (40) @(posedge clk);
        sens.hallStep();
        rdr(`MCT_OFF_STAT, rd);
        chk(rd[6], 1'b1);
        rdr(`MCT_OFF_CNT, rd);
        chk(rd < 32'h10, 1'b1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
